// ===== logic/hc_consts.vh
// constants for the parallel eeprom host controller: timing counts and page geometry
// assumes a single 100 MHz clock; every count except the load margin and synchroniser depth is derived from a time in ns
`ifndef HC_CONSTS_VH
`define HC_CONSTS_VH

`define HC_CLK_NS 10
`define HC_ADDR_W 11
`define HC_DATA_W 8
`define HC_PAGE_LSB 4
`define HC_PAGE_BYTES 16
// device times, in ns
`define HC_T_ACCESS_NS 90
`define HC_T_GLITCH_NS 10
`define HC_T_WE_NS 100
`define HC_T_BYTE_LOAD_NS 20000
`define HC_T_PROG_NS 5000000
// least times round up, longest rounds down
`define HC_ACCESS_CYC ((`HC_T_ACCESS_NS + `HC_CLK_NS - 1) / `HC_CLK_NS)
`define HC_WE_CYC ((`HC_T_WE_NS + `HC_CLK_NS - 1) / `HC_CLK_NS)
`define HC_BYTE_LOAD_CYC (`HC_T_BYTE_LOAD_NS / `HC_CLK_NS)
`define HC_PROG_CYC (`HC_T_PROG_NS / `HC_CLK_NS)
// cycles needed from a page accept to the strobe fall, kept clear of the window end
`define HC_LOAD_MARGIN 8
// synchroniser depth on the returning data lines
`define HC_SYNC_CYC 2

`endif

// ===== logic/hc_sync.v
// two-flop synchroniser for a bus of pin inputs
// assumes each bit is sampled independently; bus coherence comes from holding the pins steady
`timescale 1ns/1ps
module hc_sync #(
    parameter W = 8
) (
    input wire clk_sys,
    input wire rst,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_q;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// ===== logic/hc_ctrl.v
// host-side controller for a 2048 x 8 parallel eeprom: reads, byte and page writes,
// completion polling on the top data bit
// assumes the device pins are wired directly; the returning data lines are asynchronous
`timescale 1ns/1ps
`include "hc_consts.vh"
module hc_ctrl #(
    parameter AW = `HC_ADDR_W,
    parameter DW = `HC_DATA_W,
    parameter PAGE_BYTES = `HC_PAGE_BYTES
) (
    input wire clk_sys,
    input wire rst,
    input wire cmd_valid,
    input wire cmd_write,
    input wire cmd_last,
    input wire [AW-1:0] cmd_addr,
    input wire [DW-1:0] cmd_wdata,
    output reg cmd_ready,
    output reg rd_valid,
    output reg [DW-1:0] rd_data,
    output reg wr_done,
    output reg busy,
    output reg [AW-1:0] byte_address_lines,
    output reg [DW-1:0] bidir_data_lines_o,
    output reg bidir_data_lines_oe_n,
    input wire [DW-1:0] bidir_data_lines_i,
    output reg ce_n,
    output reg oe_n,
    output reg we_n
);
    // ----------------------------------------------------------------
    // states and counters
    // ----------------------------------------------------------------
    localparam [3:0] S_IDLE = 4'd0;
    localparam [3:0] S_RD_WAIT = 4'd1;
    localparam [3:0] S_WR_SET = 4'd2;
    localparam [3:0] S_WR_LOW = 4'd3;
    localparam [3:0] S_WR_HOLD = 4'd4;
    localparam [3:0] S_PAGE = 4'd5;
    localparam [3:0] S_POLL_WAIT = 4'd6;
    localparam [3:0] S_POLL_GAP = 4'd7;
    localparam [3:0] S_DISPATCH = 4'd8;

    // counts are worked out as integers, then cut to the counter width on purpose
    localparam integer RD_CYC_I = `HC_ACCESS_CYC + `HC_SYNC_CYC;
    localparam integer WE_CYC_I = `HC_WE_CYC;
    localparam integer LOAD_SAFE_I = `HC_BYTE_LOAD_CYC - `HC_LOAD_MARGIN;
    localparam integer LOAD_END_I = `HC_BYTE_LOAD_CYC;
    localparam integer PAGE_MAX_I = PAGE_BYTES;
    localparam [11:0] RD_CYC = RD_CYC_I[11:0];
    localparam [11:0] WE_CYC = WE_CYC_I[11:0];
    localparam [11:0] LOAD_SAFE = LOAD_SAFE_I[11:0];
    localparam [11:0] LOAD_END = LOAD_END_I[11:0];
    localparam [4:0] PAGE_MAX = PAGE_MAX_I[4:0];

    reg [3:0] st_q;
    reg [11:0] cnt_q;
    reg [11:0] win_q;
    reg [4:0] nbytes_q;
    reg pend_q;
    reg c_write_q;
    reg c_last_q;
    reg [AW-1:0] c_addr_q;
    reg [DW-1:0] c_data_q;
    reg [AW-1:0] last_addr_q;
    reg last_bit_q;
    reg page_end_q;
    wire [DW-1:0] dq_sync;

    // data lines come from the device's clock-free logic
    hc_sync #(.W(DW)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d(bidir_data_lines_i),
        .q(dq_sync)
    );

    function same_page;
        input [AW-1:0] a;
        input [AW-1:0] b;
        begin
            same_page = (a[AW-1:`HC_PAGE_LSB] == b[AW-1:`HC_PAGE_LSB]);
        end
    endfunction

    // continuation is legal only inside the byte-load window and page
    wire can_extend = c_write_q && !page_end_q && same_page(c_addr_q, last_addr_q)
        && (nbytes_q < PAGE_MAX) && (win_q < LOAD_SAFE);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= S_IDLE;
            cnt_q <= 12'h000;
            win_q <= 12'h000;
            nbytes_q <= 5'h00;
            pend_q <= 1'b0;
            c_write_q <= 1'b0;
            c_last_q <= 1'b0;
            c_addr_q <= {AW{1'b0}};
            c_data_q <= {DW{1'b0}};
            last_addr_q <= {AW{1'b0}};
            last_bit_q <= 1'b0;
            page_end_q <= 1'b0;
            cmd_ready <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= {DW{1'b0}};
            wr_done <= 1'b0;
            busy <= 1'b0;
            byte_address_lines <= {AW{1'b0}};
            bidir_data_lines_o <= {DW{1'b0}};
            bidir_data_lines_oe_n <= 1'b1;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
        end else begin
            rd_valid <= 1'b0;
            wr_done <= 1'b0;
            if (win_q != 12'hfff) begin
                win_q <= win_q + 12'h001;
            end
            if (cmd_ready && cmd_valid) begin
                cmd_ready <= 1'b0;
                pend_q <= 1'b1;
                c_write_q <= cmd_write;
                c_last_q <= cmd_last;
                c_addr_q <= cmd_addr;
                c_data_q <= cmd_wdata;
            end
            case (st_q)
                S_IDLE: begin
                    if (cmd_ready && cmd_valid) begin
                        st_q <= S_DISPATCH;
                    end else if (!pend_q) begin
                        cmd_ready <= 1'b1;
                    end
                end
                S_DISPATCH: begin
                    pend_q <= 1'b0;
                    byte_address_lines <= c_addr_q;
                    ce_n <= 1'b0;
                    if (c_write_q) begin
                        nbytes_q <= 5'h00;
                        page_end_q <= 1'b0;
                        busy <= 1'b1;
                        bidir_data_lines_o <= c_data_q;
                        bidir_data_lines_oe_n <= 1'b0;
                        oe_n <= 1'b1;
                        st_q <= S_WR_SET;
                    end else begin
                        oe_n <= 1'b0;
                        cnt_q <= RD_CYC;
                        st_q <= S_RD_WAIT;
                    end
                end
                S_RD_WAIT: begin
                    cnt_q <= cnt_q - 12'h001;
                    if (cnt_q == 12'h001) begin
                        rd_data <= dq_sync;
                        rd_valid <= 1'b1;
                        oe_n <= 1'b1;
                        ce_n <= 1'b1;
                        st_q <= S_IDLE;
                    end
                end
                S_WR_SET: begin
                    // select already low: the strobe fall is the later edge and takes the address
                    we_n <= 1'b0;
                    win_q <= 12'h000;
                    cnt_q <= WE_CYC;
                    st_q <= S_WR_LOW;
                end
                S_WR_LOW: begin
                    // pulse far wider than the glitch filter so it always counts
                    cnt_q <= cnt_q - 12'h001;
                    if (cnt_q == 12'h001) begin
                        we_n <= 1'b1;
                        st_q <= S_WR_HOLD;
                    end
                end
                S_WR_HOLD: begin
                    // data held one cycle past the strobe rise, then released with select
                    ce_n <= 1'b1;
                    bidir_data_lines_oe_n <= 1'b1;
                    last_addr_q <= byte_address_lines;
                    last_bit_q <= bidir_data_lines_o[DW-1];
                    nbytes_q <= nbytes_q + 5'h01;
                    page_end_q <= c_last_q;
                    cmd_ready <= !c_last_q;
                    st_q <= S_PAGE;
                end
                S_PAGE: begin
                    if (pend_q) begin
                        if (can_extend) begin
                            pend_q <= 1'b0;
                            byte_address_lines <= c_addr_q;
                            bidir_data_lines_o <= c_data_q;
                            bidir_data_lines_oe_n <= 1'b0;
                            ce_n <= 1'b0;
                            st_q <= S_WR_SET;
                        end else begin
                            cmd_ready <= 1'b0;
                            st_q <= S_POLL_GAP;
                        end
                    end else if (page_end_q || win_q >= LOAD_SAFE) begin
                        // let the window lapse; the device starts programming itself
                        cmd_ready <= 1'b0;
                        st_q <= S_POLL_GAP;
                    end
                end
                S_POLL_GAP: begin
                    if (win_q >= LOAD_END) begin
                        byte_address_lines <= last_addr_q;
                        ce_n <= 1'b0;
                        oe_n <= 1'b0;
                        cnt_q <= RD_CYC;
                        st_q <= S_POLL_WAIT;
                    end
                end
                S_POLL_WAIT: begin
                    cnt_q <= cnt_q - 12'h001;
                    if (cnt_q == 12'h001) begin
                        oe_n <= 1'b1;
                        ce_n <= 1'b1;
                        if (dq_sync[DW-1] == last_bit_q) begin
                            // true value back: programming has finished
                            wr_done <= 1'b1;
                            busy <= 1'b0;
                            st_q <= pend_q ? S_DISPATCH : S_IDLE;
                        end else begin
                            // inverted top bit: still programming, read again
                            st_q <= S_POLL_GAP;
                        end
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== dv/hc_ctrl_assertions.sv
// pin and command port checks for hc_ctrl
// assumes a bind to hc_ctrl; one clock, reset active high
`timescale 1ns/1ps
module hc_ctrl_chk (
    input wire clk_sys,
    input wire rst,
    input wire cmd_valid,
    input wire cmd_write,
    input wire cmd_ready,
    input wire rd_valid,
    input wire wr_done,
    input wire busy,
    input wire [10:0] byte_address_lines,
    input wire [7:0] bidir_data_lines_o,
    input wire bidir_data_lines_oe_n,
    input wire ce_n,
    input wire oe_n,
    input wire we_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // page bookkeeping
    // ----------------------------------------
    logic pend_q;
    logic [11:0] since_q;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pend_q <= 1'b0;
            since_q <= 12'h000;
        end else begin
            pend_q <= !we_n || (pend_q && !wr_done);
            since_q <= !we_n ? 12'h000 : since_q + {11'h000, since_q != 12'hfff};
        end
    end
    a_write_combo: assert property (
        !we_n |-> oe_n && !ce_n && !bidir_data_lines_oe_n) else $error("bad write combo");
    a_read_combo: assert property (
        !oe_n |-> we_n && !ce_n && bidir_data_lines_oe_n) else $error("bad read combo");
    a_we_width: assert property (
        $fell(we_n) |-> ##9 !we_n ##1 we_n) else $error("strobe width");
    a_addr_hold: assert property (
        $fell(we_n) |-> (!ce_n && $stable(byte_address_lines)
        && $stable(bidir_data_lines_o))[*8]) else $error("address moved");
    a_data_rise: assert property (
        $rose(we_n) |-> !ce_n && !bidir_data_lines_oe_n ##1 ce_n && bidir_data_lines_oe_n)
        else $error("data released early");
    a_rd_latency: assert property (
        cmd_valid && cmd_ready && !cmd_write && !busy |-> ##[12:13] (rd_valid && oe_n))
        else $error("read latency");
    a_page_gap: assert property (
        $fell(we_n) && pend_q |-> since_q < 12'd1990) else $error("page byte late");
    a_poll_wait: assert property (
        $fell(oe_n) && pend_q |-> since_q >= 12'd1990) else $error("poll too early");
    c_done: cover property (wr_done);
    c_page: cover property ($fell(we_n) && pend_q);
    c_read: cover property (rd_valid && !busy);
endmodule

// ===== dv/hc_eeprom_model.sv
// behavioural 2048 x 8 eeprom: page buffer, byte-load timer, top bit polling
// assumes pins come straight from the host; programming time shortened
`timescale 1ns/1ps
module hc_eeprom_model #(
    parameter LOAD_NS = 20000,
    parameter PROG_NS = 30000
) (
    input wire [10:0] addr,
    input wire [7:0] din,
    input wire ce_n,
    input wire oe_n,
    input wire we_n,
    output wire [7:0] dout,
    output wire drv
);
    // ----------------------------------------
    // array and page buffer
    // ----------------------------------------
    logic [7:0] mem [0:2047];
    logic [7:0] pg [0:15];
    logic [15:0] pv = 16'h0000;
    logic [10:0] a_lat;
    logic [10:0] last_a;
    logic busy_p = 1'b0;
    realtime t_fall;
    int ld_id = 0;
    wire wr = !ce_n && !we_n && oe_n;
    initial for (int i = 0; i < 2048; i++) mem[i] = 8'hff;
    assign drv = !ce_n && !oe_n && we_n;
    assign dout = (busy_p && addr == last_a) ?
        {~pg[addr[3:0]][7], mem[addr][6:0]} : mem[addr];
    task automatic prog_after(input int id, input realtime dly);
        #dly;
        if (id == ld_id) begin
            busy_p = 1'b1;
            #PROG_NS;
            for (int i = 0; i < 16; i++) begin
                if (pv[i]) mem[{last_a[10:4], i[3:0]}] = pg[i];
            end
            pv = 16'h0000;
            busy_p = 1'b0;
        end
    endtask
    always @(posedge wr) begin
        a_lat = addr;
        t_fall = $realtime;
    end
    always @(negedge wr) begin
        if (!busy_p && $realtime - t_fall >= 10.0) begin
            pg[a_lat[3:0]] = din;
            pv[a_lat[3:0]] = 1'b1;
            last_a = a_lat;
            ld_id++;
            fork
                prog_after(ld_id, t_fall + LOAD_NS - 1 - $realtime);
            join_none
        end
    end
endmodule

// ===== dv/tb.sv
// self-checking bench: hc_ctrl drives the behavioural eeprom model
// assumes checker and model compiled first
`timescale 1ns/1ps
module tb;
    logic clk_sys, rst, cmd_valid, cmd_write, cmd_last, cmd_ready, rd_valid, wr_done, busy;
    logic bidir_data_lines_oe_n, ce_n, oe_n, we_n, dev_drv;
    logic [10:0] cmd_addr, byte_address_lines, a;
    logic [7:0] cmd_wdata, rd_data, bidir_data_lines_o, dev_o;
    logic [7:0] dq_hold = 8'h00;
    logic [7:0] shadow [0:2047];
    int n_fail = 0;
    int n_checks = 0;
    // a floating bus toggles so a stale value never passes
    wire [7:0] bidir_data_lines_i = !bidir_data_lines_oe_n ? bidir_data_lines_o :
        dev_drv ? dev_o : ~dq_hold;
    hc_ctrl i_hc_ctrl (
        .clk_sys(clk_sys),
        .rst(rst),
        .cmd_valid(cmd_valid),
        .cmd_write(cmd_write),
        .cmd_last(cmd_last),
        .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready),
        .rd_valid(rd_valid),
        .rd_data(rd_data),
        .wr_done(wr_done),
        .busy(busy),
        .byte_address_lines(byte_address_lines),
        .bidir_data_lines_o(bidir_data_lines_o),
        .bidir_data_lines_oe_n(bidir_data_lines_oe_n),
        .bidir_data_lines_i(bidir_data_lines_i),
        .ce_n(ce_n),
        .oe_n(oe_n),
        .we_n(we_n)
    );
    hc_eeprom_model i_hc_eeprom_model (.addr(byte_address_lines), .din(bidir_data_lines_i),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dout(dev_o), .drv(dev_drv));
    always @(posedge clk_sys) dq_hold <= bidir_data_lines_i;
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    function automatic logic [7:0] exp_rd(input logic [10:0] ad);
        return shadow[ad];
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic issue(input logic w, input logic l, input logic [10:0] ad, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_last <= l;
        cmd_addr <= ad;
        cmd_wdata <= d;
        do begin
            @(negedge clk_sys);
            k++;
        end while (cmd_ready !== 1'b1 && k < 20000);
        check({7'h00, cmd_ready === 1'b1}, 8'h01);
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
    endtask
    task automatic wait_pulse(input logic done);
        int k;
        k = 0;
        do begin
            @(negedge clk_sys);
            k++;
        end while ((done ? wr_done : rd_valid) !== 1'b1 && k < 20000);
        check({7'h00, (done ? wr_done : rd_valid) === 1'b1}, 8'h01);
        if (done) check({7'h00, busy}, 8'h00);
    endtask
    task automatic rd(input logic [10:0] ad);
        issue(1'b0, 1'b0, ad, 8'h00);
        wait_pulse(1'b0);
        check(rd_data, exp_rd(ad));
    endtask
    task automatic page(input logic [10:0] base, input int n, input logic l);
        logic [10:0] ad;
        for (int i = 0; i < n; i++) begin
            ad = {base[10:4], base[3:0] + 4'(i)};
            shadow[ad] = 8'($urandom);
            issue(1'b1, l && i == n - 1, ad, shadow[ad]);
        end
        repeat (2) @(negedge clk_sys);
        check({7'h00, busy}, 8'h01);
        wait_pulse(1'b1);
        for (int i = 0; i < n; i++) rd({base[10:4], base[3:0] + 4'(i)});
        $display("test page of %0d done", n);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        {cmd_valid, cmd_write, cmd_last, cmd_addr, cmd_wdata} = 22'h000000;
        for (int i = 0; i < 2048; i++) shadow[i] = 8'hff;
        void'($urandom(13680));
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        rd(11'h000);
        rd(11'h7ff);
        rd(11'($urandom));
        $display("test reads done");
        page(11'h7ff, 1, 1'b1);
        page(11'($urandom), 16, 1'b1);
        page(11'h000, 3, 1'b0);
        // a byte for another page is held until the open page is polled
        a = 11'h155;
        shadow[a] = 8'h80;
        issue(1'b1, 1'b0, a, 8'h80);
        shadow[a ^ 11'h400] = 8'h01;
        issue(1'b1, 1'b1, a ^ 11'h400, 8'h01);
        wait_pulse(1'b1);
        wait_pulse(1'b1);
        rd(a);
        rd(a ^ 11'h400);
        $display("test page switch done");
        // a seventeenth byte and a read both wait for the open page's poll
        for (int i = 0; i < 17; i++) begin
            a = {7'h23, 4'(i)};
            shadow[a] = 8'($urandom);
            issue(1'b1, 1'b0, a, shadow[a]);
        end
        wait_pulse(1'b1);
        for (int i = 0; i < 16; i++) rd({7'h23, 4'(i)});
        $display("test page overflow done");
        for (int i = 0; i < 3; i++) page(11'($urandom), 1 + int'($urandom % 16), i[0]);
        give_verdict;
    end
    initial begin
        #950000;
        n_fail++;
        give_verdict;
    end
endmodule
bind hc_ctrl hc_ctrl_chk i_hc_ctrl_chk (
    .clk_sys(clk_sys),
    .rst(rst),
    .cmd_valid(cmd_valid),
    .cmd_write(cmd_write),
    .cmd_ready(cmd_ready),
    .rd_valid(rd_valid),
    .wr_done(wr_done),
    .busy(busy),
    .byte_address_lines(byte_address_lines),
    .bidir_data_lines_o(bidir_data_lines_o),
    .bidir_data_lines_oe_n(bidir_data_lines_oe_n),
    .ce_n(ce_n),
    .oe_n(oe_n),
    .we_n(we_n)
);
